// file: verilog/ext_irq_pkg.sv
package ext_irq_pkg;

    // register indices on the plain register port
    localparam logic [1:0] ADDR_CONTROL   = 2'h0;
    localparam logic [1:0] ADDR_STATUS    = 2'h1;
    localparam logic [1:0] ADDR_MASK      = 2'h2;
    localparam logic [1:0] ADDR_SERVICE   = 2'h3;

    // control register field positions
    localparam int         POS_PORTB_SENSE   = 6;
    localparam int         POS_PORTB_INV     = 5;
    localparam int         POS_PORTA_F_SENSE = 3;
    localparam int         POS_PORTA_INV     = 2;
    localparam int         POS_TOP_EDGE      = 1;
    localparam int         POS_TOP_ENABLE    = 0;

    // reset values
    localparam logic [7:0] RESET_CONTROL  = 8'h00;
    localparam logic [4:0] RESET_STATUS   = 5'h00;
    localparam logic [4:0] RESET_MASK     = 5'h00;

    // cpu level that opens the sensitivity fields
    localparam logic [1:0] PRIO_LEVEL_3   = 2'h3;

    // sensitivity codes
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE     = 2'h1;
    localparam logic [1:0] SENSE_FALL     = 2'h2;
    localparam logic [1:0] SENSE_BOTH     = 2'h3;

    // status bit positions: groups 0..3 then top-level
    localparam int         NUM_GROUPS     = 4;
    localparam int         BIT_TOP        = 4;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage

// file: verilog/group_detect.sv
module group_detect
    import ext_irq_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // pins, already synchronised
    input  wire logic [WIDTH-1:0] pins,
    // configuration
    input  wire logic [1:0]       sense,
    input  wire logic             invert,
    // request, a pulse per edge or held while at the active level
    output logic                  request
);

    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic             request;
    } state_s;

    state_s st;
    state_s next_st;

    always_comb begin
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
        logic [WIDTH-1:0] lvl;
        rise = pins & ~st.prev;
        fall = ~pins & st.prev;
        lvl  = invert ? pins : ~pins;
        next_st.prev = pins;
        unique case (sense)
            SENSE_FALL_LOW: next_st.request = |(invert ? rise : fall) | |lvl;
            SENSE_RISE:     next_st.request = |(invert ? fall : rise);
            SENSE_FALL:     next_st.request = |(invert ? rise : fall);
            SENSE_BOTH:     next_st.request = |(rise | fall);
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '{prev: {WIDTH{1'b1}}, request: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign request = st.request;

endmodule

// file: verilog/ext_irq_sense.sv
module ext_irq_sense
    import ext_irq_pkg::*;
#(
    parameter int PORTA_W = 4,
    parameter int PORTF_W = 3,
    parameter int PORTB_W = 8
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               srst,
    // register port
    input  wire logic [1:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // cpu condition register priority bits
    input  wire logic               cpu_prio_bit_hi,
    input  wire logic               cpu_prio_bit_lo,
    // port pins
    input  wire logic [PORTA_W-1:0] porta_pins,
    input  wire logic [PORTF_W-1:0] portf_pins,
    input  wire logic [PORTB_W-1:0] portb_pins,
    input  wire logic               top_irq_pin,
    // requests to the core
    output logic      [3:0]         group_pending,
    output logic                    top_level_irq,
    output logic                    irq
);

    typedef struct packed {
        logic [7:0]             ext_irq_control;
        logic [4:0]             status;
        logic [4:0]             mask;
        logic [7:0]             rdata;
        logic [3:0]             pending;
        logic                   top_pending;
        logic                   irq;
        logic [PORTA_W-1:0]     sa1;
        logic [PORTA_W-1:0]     sa2;
        logic [PORTF_W-1:0]     sf1;
        logic [PORTF_W-1:0]     sf2;
        logic [PORTB_W-1:0]     sb1;
        logic [PORTB_W-1:0]     sb2;
        logic                   st1;
        logic                   st2;
        logic                   top_prev;
    } state_s;

    state_s   st;
    state_s   next_st;
    reg_req_s req;
    logic [3:0] grp_req;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // per-group detectors, port B split into low and high nibbles
    group_detect #(.WIDTH(PORTA_W)) u_porta_low_group (
        .core_clk (core_clk),
        .srst     (srst),
        .pins     (st.sa2),
        .sense    (st.ext_irq_control[POS_PORTA_F_SENSE +: 2]),
        .invert   (st.ext_irq_control[POS_PORTA_INV]),
        .request  (grp_req[0])
    );
    group_detect #(.WIDTH(PORTF_W)) u_portf_group (
        .core_clk (core_clk),
        .srst     (srst),
        .pins     (st.sf2),
        .sense    (st.ext_irq_control[POS_PORTA_F_SENSE +: 2]),
        .invert   (1'b0),
        .request  (grp_req[1])
    );
    group_detect #(.WIDTH(PORTB_W/2)) u_portb_low_group (
        .core_clk (core_clk),
        .srst     (srst),
        .pins     (st.sb2[PORTB_W/2-1:0]),
        .sense    (st.ext_irq_control[POS_PORTB_SENSE +: 2]),
        .invert   (st.ext_irq_control[POS_PORTB_INV]),
        .request  (grp_req[2])
    );
    group_detect #(.WIDTH(PORTB_W/2)) u_portb_high_group (
        .core_clk (core_clk),
        .srst     (srst),
        .pins     (st.sb2[PORTB_W-1:PORTB_W/2]),
        .sense    (st.ext_irq_control[POS_PORTB_SENSE +: 2]),
        .invert   (1'b0),
        .request  (grp_req[3])
    );

    function automatic logic is_wr(input reg_req_s r, input logic [1:0] a);
        return r.wr && (r.addr == a);
    endfunction

    always_comb begin
        logic [7:0] cur;
        logic [7:0] new_ctl;
        logic       level3;
        logic       cfg_change;
        logic       top_edge;
        logic [4:0] events;
        logic [3:0] service;
        logic       top_service;
        next_st     = st;
        cur         = st.ext_irq_control;
        new_ctl     = cur;
        level3      = ({cpu_prio_bit_hi, cpu_prio_bit_lo} == PRIO_LEVEL_3);
        cfg_change  = 1'b0;
        top_edge    = 1'b0;
        events      = 5'h00;
        service     = 4'h0;
        top_service = 1'b0;

        // two-stage synchronisers
        next_st.sa1 = porta_pins;
        next_st.sa2 = st.sa1;
        next_st.sf1 = portf_pins;
        next_st.sf2 = st.sf1;
        next_st.sb1 = portb_pins;
        next_st.sb2 = st.sb1;
        next_st.st1 = top_irq_pin;
        next_st.st2 = st.st1;
        next_st.top_prev = st.st2;

        // control register write
        if (is_wr(req, ADDR_CONTROL)) begin
            if (level3) begin
                new_ctl[7:2] = req.wdata[7:2];
            end
            if (!cur[POS_TOP_ENABLE]) begin
                new_ctl[POS_TOP_EDGE] = req.wdata[POS_TOP_EDGE];
            end
            new_ctl[POS_TOP_ENABLE] = req.wdata[POS_TOP_ENABLE];
            cfg_change = (new_ctl[7:2] != cur[7:2]);
        end
        next_st.ext_irq_control = new_ctl;

        if (is_wr(req, ADDR_SERVICE)) begin
            service     = req.wdata[3:0];
            top_service = req.wdata[BIT_TOP];
        end

        // top-level edge detection, any cpu level
        top_edge = cur[POS_TOP_EDGE] ? (st.st2 & ~st.top_prev)
                                     : (~st.st2 & st.top_prev);
        // enable gates the edge; dropping the enable may leave one latched
        top_edge = top_edge & cur[POS_TOP_ENABLE];

        // pending group requests
        if (cfg_change) begin
            next_st.pending = 4'h0;
        end else begin
            next_st.pending = (st.pending & ~service) | grp_req;
        end
        next_st.top_pending = (st.top_pending & ~top_service) | top_edge;

        // sticky status, set wins over clear
        events = {top_edge, grp_req};
        next_st.status = st.status;
        if (is_wr(req, ADDR_STATUS)) begin
            next_st.status = st.status & ~req.wdata[4:0];
        end
        next_st.status = next_st.status | events;
        if (is_wr(req, ADDR_MASK)) begin
            next_st.mask = req.wdata[4:0];
        end
        next_st.irq = |(next_st.status & next_st.mask);

        // read data, one cycle later
        next_st.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CONTROL: next_st.rdata = cur;
                ADDR_STATUS:  next_st.rdata = {3'h0, st.status};
                ADDR_MASK:    next_st.rdata = {3'h0, st.mask};
                ADDR_SERVICE: next_st.rdata = {3'h0, st.top_pending, st.pending};
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st                 <= '0;
            st.ext_irq_control <= RESET_CONTROL;
            st.status          <= RESET_STATUS;
            st.mask            <= RESET_MASK;
            st.sa1             <= '1;
            st.sa2             <= '1;
            st.sf1             <= '1;
            st.sf2             <= '1;
            st.sb1             <= '1;
            st.sb2             <= '1;
            st.st1             <= 1'b1;
            st.st2             <= 1'b1;
            st.top_prev        <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata     = st.rdata;
    assign group_pending = st.pending;
    assign top_level_irq = st.top_pending;
    assign irq           = st.irq;

endmodule

// file: dv/ext_irq_sense_chk.sv
module ext_irq_sense_chk
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       srst,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // cpu level and requests
    input wire logic       cpu_prio_bit_hi,
    input wire logic       cpu_prio_bit_lo,
    input wire logic [3:0] group_pending,
    input wire logic       top_level_irq,
    input wire logic       irq
);
    logic [7:0] ctl;
    logic [4:0] msk;
    logic       cw;
    logic       svc;
    assign cw  = reg_wr && reg_addr == ADDR_CONTROL;
    assign svc = reg_wr && (reg_addr == ADDR_SERVICE || reg_addr == ADDR_CONTROL);
    // shadow of control and mask
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctl <= RESET_CONTROL;
            msk <= RESET_MASK;
        end else begin
            if (cw)
                ctl <= {cpu_prio_bit_hi && cpu_prio_bit_lo ? reg_wdata[7:2] : ctl[7:2],
                        ctl[0] ? ctl[1] : reg_wdata[1], reg_wdata[0]};
            if (reg_wr && reg_addr == ADDR_MASK)
                msk <= reg_wdata[4:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_reset_clears: assert property (
        disable iff (1'b0) srst |=> reg_rdata == 8'h00 && group_pending == 4'h0 && !irq)
        else $error("outputs not cleared by reset");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_ctl_readback: assert property (
        reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata == $past(ctl))
        else $error("control read back wrong");
    a_cfg_clears: assert property (
        cw && cpu_prio_bit_hi && cpu_prio_bit_lo && reg_wdata[7:2] != ctl[7:2]
        |=> group_pending == 4'h0) else $error("config change kept pending");
    a_pend_sticky: assert property (
        !svc |=> (group_pending & $past(group_pending)) == $past(group_pending))
        else $error("group pending dropped");
    a_top_sticky: assert property (
        top_level_irq && !(reg_wr && reg_addr == ADDR_SERVICE) |=> top_level_irq)
        else $error("top pending dropped");
    a_irq_masked: assert property (msk == 5'h00 && $past(msk) == 5'h00 |-> !irq)
        else $error("irq while all masked");
    a_irq_raised: assert property ($rose(top_level_irq) && msk[BIT_TOP] |-> irq)
        else $error("unmasked top event gave no irq");
endmodule

// file: dv/ext_pins.sv
module ext_pins (
    // levels asked for by the bench
    input  wire logic [15:0] want,
    input  wire logic        want_lvl3,
    // pins and cpu level
    output logic      [7:0]  portb_pins,
    output logic      [2:0]  portf_pins,
    output logic      [3:0]  porta_pins,
    output logic             top_irq_pin,
    output logic             cpu_prio_bit_hi,
    output logic             cpu_prio_bit_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    // software raises level 3 around sensitivity changes
    assign cpu_prio_bit_hi = want_lvl3;
    assign cpu_prio_bit_lo = want_lvl3;
    // pins move off the clock
    initial {portb_pins, portf_pins, porta_pins, top_irq_pin} = 16'hffff;
    always @(want) {portb_pins, portf_pins, porta_pins, top_irq_pin} <= #1.3 want;
endmodule

// file: dv/tb.sv
module tb
    import ext_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [1:0]  reg_addr = 2'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        rd_q = 1'b0;
    logic        lvl3 = 1'b0;
    logic [15:0] want = 16'hffff;
    logic [7:0]  ctl = 8'h00;
    logic [7:0]  reg_rdata, portb_pins;
    logic [3:0]  porta_pins, group_pending;
    logic [2:0]  portf_pins;
    logic        cpu_prio_bit_hi, cpu_prio_bit_lo, top_irq_pin, top_level_irq, irq;
    logic [7:0]  exp_q[$];
    int          mismatches = 0;
    int          num_checks = 0;
    always #2 core_clk = ~core_clk;
    ext_pins u_ext_pins (.want, .want_lvl3(lvl3), .portb_pins, .portf_pins, .porta_pins,
        .top_irq_pin, .cpu_prio_bit_hi, .cpu_prio_bit_lo);
    ext_irq_sense u_ext_irq_sense (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cpu_prio_bit_hi, .cpu_prio_bit_lo, .porta_pins, .portf_pins, .portb_pins,
        .top_irq_pin, .group_pending, .top_level_irq, .irq);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        if (a == ADDR_CONTROL)
            ctl = {lvl3 ? d[7:2] : ctl[7:2], ctl[0] ? ctl[1] : d[1], d[0]};
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
    endtask
    // read results against the oldest note
    always @(posedge core_clk) begin
        if (rd_q)
            check(reg_rdata, exp_q.pop_front(), "reg_rdata");
        rd_q <= reg_rd;
    end
    // {rise, fall, high level, low level}
    function automatic logic [3:0] sens(input logic [1:0] c, input logic inv);
        logic [3:0] s;
        s = c == 2'h0 ? 4'b0101 : c == 2'h1 ? 4'b1000 : c == 2'h2 ? 4'b0100 : 4'b1100;
        return inv ? {s[2], s[3], s[0], s[1]} : s;
    endfunction
    function automatic logic [7:0] grp(input logic [2:0] c, input logic [3:0] m);
        return {4'h0, |(sens(~c[2:1], 1'b0) & m), |(sens(~c[2:1], c[0]) & m),
                |(sens(c[2:1], 1'b0) & m), |(sens(c[2:1], c[0]) & m)};
    endfunction
    task automatic phase(input logic lv, input logic [2:0] c, input logic [3:0] m);
        want <= {16{lv}};
        cyc(8);
        check({4'h0, group_pending}, grp(c, m), "group_pending");
        wr(ADDR_SERVICE, 8'h0f);
        cyc(8);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h48c7));
        cyc(3);
        srst <= 1'b0;
        cyc(1);
        rd(ADDR_CONTROL, RESET_CONTROL);
        rd(ADDR_MASK, 8'h00);
        $display("reset test done");
        repeat (24) begin
            lvl3 <= 1'($urandom);
            cyc(1);
            wr(ADDR_CONTROL, 8'($urandom));
            rd(ADDR_CONTROL, ctl);
        end
        $display("register test done");
        lvl3 <= 1'b1;
        cyc(1);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CONTROL, {~i[2:1], i[0], i[2:1], i[0], 2'b00});
            // let requests under the old sensitivity drain before servicing
            cyc(2);
            wr(ADDR_SERVICE, 8'h0f);
            phase(1'b1, i[2:0], 4'b0010);
            phase(1'b0, i[2:0], 4'b0111);
            phase(1'b1, i[2:0], 4'b1011);
        end
        $display("sensitivity test done");
        for (int e = 0; e < 2; e++) begin
            want[0] <= ~e[0];
            wr(ADDR_MASK, {3'h0, e[0], 4'h0});
            wr(ADDR_CONTROL, {6'h24, e[0], 1'b0});
            wr(ADDR_CONTROL, {6'h24, e[0], 1'b1});
            cyc(8);
            wr(ADDR_SERVICE, 8'h10);
            wr(ADDR_STATUS, 8'h1f);
            cyc(2);
            want[0] <= e[0];
            cyc(8);
            check({6'h0, irq, top_level_irq}, {6'h0, e[0], 1'b1}, "top irq");
            rd(ADDR_STATUS, 8'h10);
            wr(ADDR_STATUS, 8'h1f);
            wr(ADDR_CONTROL, {6'h24, ~e[0], 1'b1});
            rd(ADDR_CONTROL, ctl);
            check({7'h0, irq}, 8'h00, "irq cleared");
            wr(ADDR_CONTROL, {6'h24, ~e[0], 1'b0});
            cyc(8);
            wr(ADDR_SERVICE, 8'h10);
            want[0] <= ~e[0];
            cyc(8);
            want[0] <= e[0];
            cyc(8);
            check({7'h0, top_level_irq}, 8'h00, "top disabled");
        end
        $display("top level test done");
        print_verdict();
    end
endmodule
bind ext_irq_sense ext_irq_sense_chk u_ext_irq_sense_chk (.core_clk, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_prio_bit_hi, .cpu_prio_bit_lo,
    .group_pending, .top_level_irq, .irq);
